// *** watchdog_and_system_options_bench.sv ***
`timescale 1ns/1ps
module watchdog_and_system_options_bench;
    import wdog_pkg::*;

    // ----------------------------------------
    // signals and design
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic stop_req_i = 1'b0;
    logic [7:0] rdata_o;
    logic wdog_reset_o;
    logic illegal_op_reset_o;
    logic stop_enter_o;
    logic serial2_tx_on_port_e_o;
    logic i2c_on_port_e_o;
    logic irq_o;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    wdog_sysopt #(.LP_DIV(4)) dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_req_i(stop_req_i),
        .wdog_reset_o(wdog_reset_o), .illegal_op_reset_o(illegal_op_reset_o),
        .stop_enter_o(stop_enter_o), .serial2_tx_on_port_e_o(serial2_tx_on_port_e_o),
        .i2c_on_port_e_o(i2c_on_port_e_o), .irq_o(irq_o)
    );

    // clock at 100 MHz
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // hang guard counts a mismatch and closes the run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_fail++;
            final_report();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask

    task automatic service();
        wr(ADDR_SERVICE, SERVICE_KEY_A);
        wr(ADDR_SERVICE, SERVICE_KEY_B);
    endtask

    // counts cycles until a watchdog reset pulse, at most max
    task automatic wait_wdog(input int max, output int cnt);
        cnt = 0;
        #1;
        while (cnt < max && wdog_reset_o !== 1'b1)
        begin
            @(posedge clk_i);
            #1;
            cnt++;
        end
    endtask

    task automatic stop_pulse();
        @(posedge clk_i);
        stop_req_i <= 1'b1;
        @(posedge clk_i);
        stop_req_i <= 1'b0;
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_and_lock();
        do_reset();
        rd_chk("options one reset", ADDR_OPTIONS_ONE, 8'hC0);
        rd_chk("options two reset", ADDR_OPTIONS_TWO, 8'h00);
        rd_chk("unmapped read", 16'h1807, 8'h00);
        wr(ADDR_OPTIONS_ONE, 8'h38);
        wr(ADDR_OPTIONS_ONE, 8'hC0);
        rd_chk("options one locked", ADDR_OPTIONS_ONE, 8'h38);
        check("serial2 route", serial2_tx_on_port_e_o, 1'b1);
        check("i2c route", i2c_on_port_e_o, 1'b1);
        check("irq masked", irq_o, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h04);
        @(posedge clk_i);
        #1;
        check("irq unmasked", irq_o, 1'b1);
        rd_chk("status late write", ADDR_IRQ_STATUS, 8'h04);
        @(posedge clk_i);
        #1;
        check("irq cleared", irq_o, 1'b0);
        stop_pulse();
        check("stop enter", stop_enter_o, 1'b1);
        check("no illegal", illegal_op_reset_o, 1'b0);
        $display("test reset_and_lock done");
    endtask

    task automatic t_disabled_stop();
        do_reset();
        wr(ADDR_OPTIONS_TWO, 8'h80);
        rd_chk("options two bits", ADDR_OPTIONS_TWO, 8'h80);
        wr(ADDR_OPTIONS_ONE, 8'h00);
        stop_pulse();
        check("serial2 port f", serial2_tx_on_port_e_o, 1'b0);
        check("i2c port f", i2c_on_port_e_o, 1'b0);
        check("illegal op", illegal_op_reset_o, 1'b1);
        check("stop refused", stop_enter_o, 1'b0);
        wait_wdog(8400, n);
        check("disabled watchdog", n, 8400);
        $display("test disabled_stop done");
    endtask

    task automatic t_low_power();
        int lim;
        for (int c = 1; c <= 3; c++)
        begin
            lim = (c == 1) ? LP_TIMEOUT_1 : (c == 2) ? LP_TIMEOUT_2 : LP_TIMEOUT_3;
            do_reset();
            wr(ADDR_OPTIONS_TWO, 8'h40);
            wr(ADDR_OPTIONS_ONE, 8'(c << 6));
            repeat (80) @(posedge clk_i);
            service();
            wait_wdog(5000, n);
            check("lp service restart", n >= lim * 4 - 6 && n <= lim * 4 + 4, 1'b1);
            check("lp timeout count", n >= lim * 4 - 6 && n <= lim * 4 + 4, 1'b1);
            check("lp reset pulse", wdog_reset_o, 1'b1);
        end
        $display("test low_power done");
    endtask

    task automatic t_bus_window();
        do_reset();
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_OPTIONS_TWO, 8'hC0);
        wr(ADDR_OPTIONS_ONE, 8'h40);
        service();
        wait_wdog(5, n);
        check("early service reset", wdog_reset_o, 1'b1);
        @(posedge clk_i);
        wait_wdog(6300, n);
        check("counter cleared", n, 6300);
        service();
        wait_wdog(8300, n);
        check("late service ok", n >= 8180 && n <= 8196, 1'b1);
        check("bus timeout", wdog_reset_o, 1'b1);
        @(posedge clk_i);
        #1;
        check("irq raised", irq_o, 1'b1);
        rd_chk("status bus", ADDR_IRQ_STATUS, 8'h03);
        rd_chk("status cleared", ADDR_IRQ_STATUS, 8'h00);
        check("irq dropped", irq_o, 1'b0);
        $display("test bus_window done");
    endtask

    // codes 10 and 11 on the bus clock keep the window shut past the code 01 opening
    task automatic t_bus_wide_window();
        for (int c = 2; c <= 3; c++)
        begin
            do_reset();
            wr(ADDR_OPTIONS_TWO, 8'hC0);
            wr(ADDR_OPTIONS_ONE, 8'(c << 6));
            repeat (6300) @(posedge clk_i);
            service();
            wait_wdog(5, n);
            check("wide window early", wdog_reset_o, 1'b1);
            rd_chk("status early", ADDR_IRQ_STATUS, 8'h02);
        end
        $display("test bus_wide_window done");
    endtask

    // ----------------------------------------
    // closing report and main sequence
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset_and_lock();
        t_disabled_stop();
        t_low_power();
        t_bus_window();
        t_bus_wide_window();
        final_report();
    end
endmodule

// *** wdog_pkg.sv ***
package wdog_pkg;

    // register map
    localparam logic [15:0] ADDR_OPTIONS_ONE = 16'h1802;
    localparam logic [15:0] ADDR_OPTIONS_TWO = 16'h1803;
    localparam logic [15:0] ADDR_SERVICE = 16'h1804;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'h1805;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h1806;

    // field positions
    localparam int PERIOD_HI = 7;
    localparam int PERIOD_LO = 6;
    localparam int STOP_EN_BIT = 5;
    localparam int SERIAL2_SEL_BIT = 4;
    localparam int I2C_SEL_BIT = 3;
    localparam int CLK_SEL_BIT = 7;
    localparam int WINDOW_EN_BIT = 6;

    // reset values and write masks
    localparam logic [7:0] OPTIONS_ONE_RESET = 8'hC0;
    localparam logic [7:0] OPTIONS_TWO_RESET = 8'h00;
    localparam logic [7:0] OPTIONS_ONE_MASK = 8'hF8;
    localparam logic [7:0] OPTIONS_TWO_MASK = 8'hC0;

    // service sequence, written in order to the service address
    localparam logic [7:0] SERVICE_KEY_A = 8'h55;
    localparam logic [7:0] SERVICE_KEY_B = 8'hAA;

    // timeouts (low-power counts and bus counts) and window openings
    // one bit wider than the counter so the longest bus timeout is exact
    localparam logic [18:0] LP_TIMEOUT_1 = 19'h00020;
    localparam logic [18:0] LP_TIMEOUT_2 = 19'h00100;
    localparam logic [18:0] LP_TIMEOUT_3 = 19'h00400;
    localparam logic [18:0] BUS_TIMEOUT_1 = 19'h02000;
    localparam logic [18:0] BUS_TIMEOUT_2 = 19'h10000;
    localparam logic [18:0] BUS_TIMEOUT_3 = 19'h40000;
    localparam logic [17:0] BUS_WINDOW_1 = 18'h01800;
    localparam logic [17:0] BUS_WINDOW_2 = 18'h0C000;
    localparam logic [17:0] BUS_WINDOW_3 = 18'h30000;

    // low-power clock: 1 kHz against a 100 MHz bus clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int LP_PERIOD_NS = 1000000;
    localparam int LP_DIV_CYCLES = LP_PERIOD_NS / CLK_PERIOD_NS;

    // status bits
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_EARLY_BIT = 1;
    localparam int IRQ_LATE_WRITE_BIT = 2;

    // decoded watchdog configuration
    typedef struct packed {
        logic enable;
        logic bus_src;
        logic windowed;
        logic [18:0] limit;
        logic [17:0] window;
    } wdog_cfg_t;

endpackage

// *** wdog_sysopt.sv ***
`timescale 1ns/1ps
module wdog_sysopt
    import wdog_pkg::*;
#(
    parameter int LP_DIV = LP_DIV_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // core events
    input wire logic stop_req_i,
    // resets and mode
    output logic wdog_reset_o,
    output logic illegal_op_reset_o,
    output logic stop_enter_o,
    // pin routing
    output logic serial2_tx_on_port_e_o,
    output logic i2c_on_port_e_o,
    // interrupt
    output logic irq_o
);

    // elaboration check: the divider needs at least two states
    if (LP_DIV < 2)
    begin
        $error("LP_DIV must be at least 2");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] opt_one_reg;
    logic [7:0] opt_two_reg;
    logic written_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic key_a_seen_reg;
    logic [17:0] count_reg;
    logic [31:0] lp_div_reg;
    logic service;
    logic timeout_hit;
    logic early;
    logic tick;
    wdog_cfg_t cfg;

    // options register one, write-once
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            opt_one_reg <= OPTIONS_ONE_RESET;
            written_reg <= 1'b0;
        end
        else if (wr_i && addr_i == ADDR_OPTIONS_ONE && !written_reg)
        begin
            opt_one_reg <= wdata_i & OPTIONS_ONE_MASK;
            written_reg <= 1'b1;
        end
    end

    // options register two: clock select and window enable
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            opt_two_reg <= OPTIONS_TWO_RESET;
        else if (wr_i && addr_i == ADDR_OPTIONS_TWO)
            opt_two_reg <= wdata_i & OPTIONS_TWO_MASK;
    end

    // interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            irq_mask_reg <= 3'h0;
        else if (wr_i && addr_i == ADDR_IRQ_MASK)
            irq_mask_reg <= wdata_i[2:0];
    end

    // ----------------------------------------------------------------
    // watchdog configuration decode
    // ----------------------------------------------------------------
    always_comb
    begin
        cfg.enable = (opt_one_reg[PERIOD_HI:PERIOD_LO] != 2'b00);
        cfg.bus_src = opt_two_reg[CLK_SEL_BIT];
        cfg.windowed = cfg.bus_src && opt_two_reg[WINDOW_EN_BIT];
        cfg.limit = LP_TIMEOUT_1;
        cfg.window = 18'h00000;
        case ({cfg.bus_src, opt_one_reg[PERIOD_HI:PERIOD_LO]})
            3'b001: cfg.limit = LP_TIMEOUT_1;
            3'b010: cfg.limit = LP_TIMEOUT_2;
            3'b011: cfg.limit = LP_TIMEOUT_3;
            3'b101:
            begin
                cfg.limit = BUS_TIMEOUT_1;
                cfg.window = BUS_WINDOW_1;
            end
            3'b110:
            begin
                cfg.limit = BUS_TIMEOUT_2;
                cfg.window = BUS_WINDOW_2;
            end
            3'b111:
            begin
                cfg.limit = BUS_TIMEOUT_3;
                cfg.window = BUS_WINDOW_3;
            end
            default: cfg.limit = LP_TIMEOUT_1;
        endcase
    end

    // ----------------------------------------------------------------
    // low-power 1 kHz time base from a fixed divider
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            lp_div_reg <= 32'h00000000;
        else if (lp_div_reg == 32'(LP_DIV - 1))
            lp_div_reg <= 32'h00000000;
        else
            lp_div_reg <= lp_div_reg + 32'h00000001;
    end

    assign tick = cfg.bus_src ? 1'b1 : (lp_div_reg == 32'(LP_DIV - 1));

    // service key sequence
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            key_a_seen_reg <= 1'b0;
        else if (wr_i && addr_i == ADDR_SERVICE)
            key_a_seen_reg <= (wdata_i == SERVICE_KEY_A);
    end

    assign service = wr_i && addr_i == ADDR_SERVICE && key_a_seen_reg
                     && wdata_i == SERVICE_KEY_B;
    assign early = service && cfg.enable && cfg.windowed && count_reg < cfg.window;
    // a valid service on the last tick restarts instead of resetting
    assign timeout_hit = cfg.enable && tick && !service &&
                         (({1'b0, count_reg} + 19'h00001) >= cfg.limit);

    // watchdog counter
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            count_reg <= 18'h00000;
        else if (!cfg.enable || service || timeout_hit)
            count_reg <= 18'h00000;
        else if (tick)
            count_reg <= count_reg + 18'h00001;
    end

    // reset requests, stop and routing outputs
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            wdog_reset_o <= 1'b0;
            illegal_op_reset_o <= 1'b0;
            stop_enter_o <= 1'b0;
        end
        else
        begin
            wdog_reset_o <= timeout_hit || early;
            illegal_op_reset_o <= stop_req_i && !opt_one_reg[STOP_EN_BIT];
            stop_enter_o <= stop_req_i && opt_one_reg[STOP_EN_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            serial2_tx_on_port_e_o <= 1'b0;
            i2c_on_port_e_o <= 1'b0;
        end
        else
        begin
            serial2_tx_on_port_e_o <= opt_one_reg[SERIAL2_SEL_BIT];
            i2c_on_port_e_o <= opt_one_reg[I2C_SEL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // interrupts and read data
    // ----------------------------------------------------------------
    logic [2:0] irq_set;
    assign irq_set = {wr_i && addr_i == ADDR_OPTIONS_ONE && written_reg, early, timeout_hit};

    // sticky status, read clears, a new event wins
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            irq_status_reg <= 3'h0;
        else if (rd_i && addr_i == ADDR_IRQ_STATUS)
            irq_status_reg <= irq_set;
        else
            irq_status_reg <= irq_status_reg | irq_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((irq_status_reg | irq_set) & irq_mask_reg &
                       ~({3{rd_i && addr_i == ADDR_IRQ_STATUS}} & ~irq_set));
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            case (addr_i)
                ADDR_OPTIONS_ONE: rdata_o <= opt_one_reg;
                ADDR_OPTIONS_TWO: rdata_o <= opt_two_reg;
                ADDR_IRQ_STATUS: rdata_o <= {5'h00, irq_status_reg};
                ADDR_IRQ_MASK: rdata_o <= {5'h00, irq_mask_reg};
                default: rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_write_once;
        @(posedge clk_i) disable iff (!nrst_i)
        (written_reg && wr_i && addr_i == ADDR_OPTIONS_ONE) |=> $stable(opt_one_reg);
    endproperty
    a_write_once: assert property (p_write_once) else $error("late write changed options one");

    property p_first_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (!written_reg && wr_i && addr_i == ADDR_OPTIONS_ONE)
            |=> opt_one_reg == ($past(wdata_i) & OPTIONS_ONE_MASK);
    endproperty
    a_first_write: assert property (p_first_write) else $error("first write not stored");

    property p_disabled;
        @(posedge clk_i) disable iff (!nrst_i)
        (opt_one_reg[PERIOD_HI:PERIOD_LO] == 2'b00) |=> count_reg == 18'h00000 && !timeout_hit;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled watchdog counted");

    property p_stop;
        @(posedge clk_i) disable iff (!nrst_i)
        (stop_req_i && !opt_one_reg[STOP_EN_BIT]) |=> illegal_op_reset_o && !stop_enter_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop without enable not refused");

    property p_timeout;
        @(posedge clk_i) disable iff (!nrst_i)
        timeout_hit |=> wdog_reset_o && count_reg == 18'h00000;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not reset");

    property p_bus_limit;
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg.enable && cfg.bus_src) |-> {1'b0, count_reg} < cfg.limit;
    endproperty
    a_bus_limit: assert property (p_bus_limit) else $error("count passed limit");

    property p_early;
        @(posedge clk_i) disable iff (!nrst_i)
        early |=> wdog_reset_o;
    endproperty
    a_early: assert property (p_early) else $error("early service not punished");

    property p_service;
        @(posedge clk_i) disable iff (!nrst_i)
        (service && !early) |=> count_reg == 18'h00000 && !wdog_reset_o;
    endproperty
    a_service: assert property (p_service) else $error("service did not restart");

    property p_route;
        @(posedge clk_i) disable iff (!nrst_i)
        ##1 i2c_on_port_e_o == $past(opt_one_reg[I2C_SEL_BIT]);
    endproperty
    a_route: assert property (p_route) else $error("i2c route wrong");

    c_timeout: cover property (@(posedge clk_i) disable iff (!nrst_i) wdog_reset_o);
    c_service: cover property (@(posedge clk_i) disable iff (!nrst_i) service && cfg.enable);
    c_late_write: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_set[IRQ_LATE_WRITE_BIT]);

endmodule
